// ### core/sync_serial_master_transmit.sv
// How it works
// - two lines, half duplex data and clock
// - data bits only, no start/stop
// - master when sync, clock source, enable set
// - transmit direction when both receive enables clear
// - clock pin driven in any sync master mode
// - data changes on leading clock edge
// - one clock per data bit, no extra
// - data and clock drivers enabled automatically
// - writing holding register starts transmission
// - new character waits while shifter busy
// - empty shifter loads immediately and starts
// - data bit held leading edge to leading edge
// - shift register not in address map
// - nine-bit mode sends ninth data bit
// - irq needs enable, peripheral and global
// - flag set on holding-to-shifter handover
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_master_transmit #(
  parameter int LOW_PRESCALE  = 4,
  parameter int HIGH_PRESCALE = 1
) (
  input  wire logic        pclk,          // apb clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic             pready,        // apb ready
  output logic [31:0]      prdata,        // apb read data
  output logic             pslverr,       // apb error, unmapped address
  output logic             shift_clock_o, // clock pin level
  output logic             shift_clock_oe,// clock pin driver enable
  input  wire logic        shift_clock_i, // clock pin readback (unused as master)
  output logic             serial_data_o, // data pin level
  output logic             serial_data_oe,// data pin driver enable
  input  wire logic        serial_data_i, // data pin readback (unused here)
  output logic             irq            // transmit interrupt request
);
  logic [7:0]  txsc_ff;
  logic [7:0]  rxsc_ff;
  logic [7:0]  baud_ff;
  logic [7:0]  hold_ff;
  logic        hold_full_ff;
  logic [7:0]  pie_ff;
  logic [7:0]  pir_ff;
  logic [7:0]  core_ff;
  logic [8:0]  tsr_ff;
  logic [3:0]  bits_left_ff;
  sync_tx_pkg::shift_state_t state_ff;
  sync_tx_pkg::shift_state_t nxt_state;
  logic        wr;
  logic        rd_en;
  logic        mapped;
  logic        master;
  logic        tx_dir;
  logic        tx_run;
  logic        tick;
  logic        load;
  logic        hold_wr;
  logic [7:0]  rd_mux;
  logic        shift_empty;

  assign wr      = psel && penable && pwrite;
  // read data is captured at setup so it stands through the access cycle
  assign rd_en   = psel && !penable && !pwrite;
  assign hold_wr = wr && paddr == sync_tx_pkg::OFS_TX_HOLDING;
  assign master  = rxsc_ff[sync_tx_pkg::BIT_SERIAL_PORT_ENABLE]
                 && txsc_ff[sync_tx_pkg::BIT_SYNC_SELECT]
                 && txsc_ff[sync_tx_pkg::BIT_CLOCK_SOURCE_SELECT];
  assign tx_dir  = !rxsc_ff[sync_tx_pkg::BIT_SINGLE_RX_ENABLE]
                 && !rxsc_ff[sync_tx_pkg::BIT_CONTINUOUS_RX_EN];
  assign tx_run  = master && tx_dir && txsc_ff[sync_tx_pkg::BIT_TRANSMIT_ENABLE];
  assign shift_empty = state_ff == sync_tx_pkg::ST_IDLE;
  // shifter takes the held character only when idle
  assign load    = tx_run && hold_full_ff && shift_empty;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    case (paddr)
      sync_tx_pkg::OFS_TX_STATUS_CONTROL: rd_mux = txsc_ff;
      sync_tx_pkg::OFS_RX_STATUS_CONTROL: rd_mux = rxsc_ff;
      sync_tx_pkg::OFS_BAUD_DIVIDER:      rd_mux = baud_ff;
      sync_tx_pkg::OFS_TX_HOLDING:        rd_mux = 8'h00; // write only
      sync_tx_pkg::OFS_PERIPH_IRQ_EN_1:   rd_mux = pie_ff;
      sync_tx_pkg::OFS_PERIPH_IRQ_FLAG_1: rd_mux = pir_ff;
      sync_tx_pkg::OFS_CORE_IRQ_CONTROL:  rd_mux = core_ff;
      default:                            mapped = 1'b0;
    endcase
  end

  // zero-wait apb: ready is registered from the setup phase, so it is high in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= rd_en ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // writes commit at the access phase edge where pready is high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txsc_ff <= sync_tx_pkg::TXSC_RESET;
      rxsc_ff <= sync_tx_pkg::RXSC_RESET;
      baud_ff <= sync_tx_pkg::BYTE_RESET;
      pie_ff  <= sync_tx_pkg::BYTE_RESET;
      core_ff <= sync_tx_pkg::BYTE_RESET;
    end
    else
    begin
      if (wr && pready && paddr == sync_tx_pkg::OFS_TX_STATUS_CONTROL)
        txsc_ff <= (pwdata[7:0] & sync_tx_pkg::TXSC_WMASK)
                 | (txsc_ff & ~sync_tx_pkg::TXSC_WMASK);
      if (wr && pready && paddr == sync_tx_pkg::OFS_RX_STATUS_CONTROL)
        rxsc_ff <= pwdata[7:0] & sync_tx_pkg::RXSC_WMASK;
      if (wr && pready && paddr == sync_tx_pkg::OFS_BAUD_DIVIDER)
        baud_ff <= pwdata[7:0];
      if (wr && pready && paddr == sync_tx_pkg::OFS_PERIPH_IRQ_EN_1)
        pie_ff  <= pwdata[7:0];
      if (wr && pready && paddr == sync_tx_pkg::OFS_CORE_IRQ_CONTROL)
        core_ff <= pwdata[7:0];
      txsc_ff[sync_tx_pkg::BIT_SHIFT_REG_EMPTY] <= shift_empty && !load;
    end
  end

  // holding register; a write while full overwrites, as software should poll the flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_ff      <= sync_tx_pkg::BYTE_RESET;
      hold_full_ff <= 1'b0;
    end
    else if (hold_wr && pready)
    begin
      hold_ff      <= pwdata[7:0];
      hold_full_ff <= 1'b1;
    end
    else if (load)
      hold_full_ff <= 1'b0;
  end

  // transmit flag: high whenever the holding register is free; set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pir_ff <= sync_tx_pkg::BYTE_RESET;
    else
    begin
      pir_ff <= 8'h00;
      pir_ff[sync_tx_pkg::BIT_TX_IRQ] <= load || (!hold_full_ff && !(hold_wr && pready));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= pir_ff[sync_tx_pkg::BIT_TX_IRQ] && pie_ff[sync_tx_pkg::BIT_TX_IRQ]
          && core_ff[sync_tx_pkg::BIT_PERIPH_IRQ_ENABLE]
          && core_ff[sync_tx_pkg::BIT_GLOBAL_IRQ_ENABLE];
  end

  baud_tick_gen #(
    .LOW_PRESCALE  (LOW_PRESCALE),
    .HIGH_PRESCALE (HIGH_PRESCALE)
  ) u_baud (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (!shift_empty),
    .high_speed (txsc_ff[sync_tx_pkg::BIT_HIGH_SPEED_BAUD]),
    .divider    (baud_ff),
    .tick       (tick)
  );

  // ST_LOW: first half of a bit (clock low, data just changed); ST_HIGH: trailing half
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      sync_tx_pkg::ST_IDLE: if (load) nxt_state = sync_tx_pkg::ST_LOW;
      sync_tx_pkg::ST_LOW:  if (tick) nxt_state = sync_tx_pkg::ST_HIGH;
      sync_tx_pkg::ST_HIGH:
        if (tick)
          nxt_state = (bits_left_ff == 4'h1) ? sync_tx_pkg::ST_IDLE : sync_tx_pkg::ST_LOW;
      default:              nxt_state = sync_tx_pkg::ST_IDLE;
    endcase
    if (!tx_run)
      nxt_state = sync_tx_pkg::ST_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= sync_tx_pkg::ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // shifter: no framing bits, lsb first, ninth bit last
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tsr_ff       <= 9'h000;
      bits_left_ff <= 4'h0;
    end
    else if (load)
    begin
      tsr_ff       <= {txsc_ff[sync_tx_pkg::BIT_TX_NINTH_DATA], hold_ff};
      bits_left_ff <= txsc_ff[sync_tx_pkg::BIT_NINE_BIT_TX_SELECT]
                    ? 4'(sync_tx_pkg::DATA_BITS + 1) : 4'(sync_tx_pkg::DATA_BITS);
    end
    else if (state_ff == sync_tx_pkg::ST_HIGH && tick)
    begin
      tsr_ff       <= {1'b0, tsr_ff[8:1]};
      bits_left_ff <= bits_left_ff - 4'h1;
    end
  end

  // pins: data updates with the falling (leading) clock edge and holds a full period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_data_o <= 1'b0;
      shift_clock_o <= 1'b0;
    end
    else
    begin
      serial_data_o <= (nxt_state == sync_tx_pkg::ST_IDLE) ? 1'b0 :
                       (load ? hold_ff[0] :
                        ((state_ff == sync_tx_pkg::ST_HIGH && tick) ? tsr_ff[1] : tsr_ff[0]));
      shift_clock_o <= nxt_state == sync_tx_pkg::ST_HIGH;
    end
  end

  // drivers follow configuration; never drive data while configured to receive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_clock_oe <= 1'b0;
      serial_data_oe <= 1'b0;
    end
    else
    begin
      shift_clock_oe <= master;
      serial_data_oe <= master && tx_dir;
    end
  end
endmodule : sync_serial_master_transmit
`default_nettype wire

// ### core/sync_tx_pkg.sv
package sync_tx_pkg;
  // register byte offsets on the APB bus
  localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RX_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BAUD_DIVIDER      = 8'h08;
  localparam logic [7:0] OFS_TX_HOLDING        = 8'h0C;
  localparam logic [7:0] OFS_PERIPH_IRQ_EN_1   = 8'h10;
  localparam logic [7:0] OFS_PERIPH_IRQ_FLAG_1 = 8'h14;
  localparam logic [7:0] OFS_CORE_IRQ_CONTROL  = 8'h18;
  // transmit_status_control fields
  localparam int BIT_CLOCK_SOURCE_SELECT = 7;
  localparam int BIT_NINE_BIT_TX_SELECT  = 6;
  localparam int BIT_TRANSMIT_ENABLE     = 5;
  localparam int BIT_SYNC_SELECT         = 4;
  localparam int BIT_HIGH_SPEED_BAUD     = 2;
  localparam int BIT_SHIFT_REG_EMPTY     = 1;
  localparam int BIT_TX_NINTH_DATA       = 0;
  localparam logic [7:0] TXSC_RESET = 8'h02;
  localparam logic [7:0] TXSC_WMASK = 8'hF5;
  // receive_status_control fields
  localparam int BIT_SERIAL_PORT_ENABLE  = 7;
  localparam int BIT_SINGLE_RX_ENABLE    = 5;
  localparam int BIT_CONTINUOUS_RX_EN    = 4;
  localparam logic [7:0] RXSC_RESET = 8'h00;
  localparam logic [7:0] RXSC_WMASK = 8'hB0;
  // irq enable / flag / core control fields
  localparam int BIT_TX_IRQ              = 4;
  localparam int BIT_GLOBAL_IRQ_ENABLE   = 7;
  localparam int BIT_PERIPH_IRQ_ENABLE   = 6;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int DATA_BITS = 8;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOW   = 2'b01,
    ST_HIGH  = 2'b10
  } shift_state_t;
endpackage : sync_tx_pkg

// ### core/baud_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
// half-bit tick generator: one tick every (divider+1)*prescale cycles
module baud_tick_gen #(
  parameter int LOW_PRESCALE  = 4,
  parameter int HIGH_PRESCALE = 1
) (
  input  wire logic       pclk,      // system clock
  input  wire logic       presetn,   // async reset, active low
  input  wire logic       run,       // count while high
  input  wire logic       high_speed,// select fast prescale
  input  wire logic [7:0] divider,   // baud divider value
  output logic            tick       // one-cycle pulse
);
  logic [9:0] cnt_ff;
  logic [9:0] limit;

  always_comb
  begin
    if (high_speed)
      limit = 10'(({2'b00, divider} + 10'h001) * 10'(HIGH_PRESCALE) - 10'h001);
    else
      limit = 10'(({2'b00, divider} + 10'h001) * 10'(LOW_PRESCALE) - 10'h001);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= 10'h000;
    else if (!run || cnt_ff >= limit)
      cnt_ff <= 10'h000;
    else
      cnt_ff <= cnt_ff + 10'h001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick <= 1'b0;
    else
      tick <= run && (cnt_ff >= limit);
  end
endmodule : baud_tick_gen
`default_nettype wire

// ### verification/sync_tx_props.sv
`timescale 1ns/1ps
`default_nettype none
module sync_tx_props (
  input wire logic pclk,           // clock
  input wire logic presetn,        // reset, active low
  input wire logic psel,           // select
  input wire logic penable,        // access phase
  input wire logic pready,         // ready
  input wire logic pslverr,        // error
  input wire logic shift_clock_o,  // clock pin
  input wire logic shift_clock_oe, // clock driver enable
  input wire logic serial_data_o,  // data pin
  input wire logic serial_data_oe  // data driver enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready_pulse;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready not one cycle after setup");
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_clk_driven;
    shift_clock_o |-> shift_clock_oe;
  endproperty
  a_clk_driven: assert property (p_clk_driven) else $error("clock high, driver off");
  property p_data_with_clk;
    serial_data_oe |-> shift_clock_oe;
  endproperty
  a_data_with_clk: assert property (p_data_with_clk) else $error("data driven, clock not");
  property p_bit_stable;
    shift_clock_o |-> $stable(serial_data_o);
  endproperty
  a_bit_stable: assert property (p_bit_stable) else $error("data moved, clock high");
  property p_rx_no_clock;
    shift_clock_oe && !serial_data_oe |-> !$rose(shift_clock_o);
  endproperty
  a_rx_no_clock: assert property (p_rx_no_clock) else $error("clock in receive");
  property p_pulse_ends;
    $rose(shift_clock_o) |-> ##[1:1000] !shift_clock_o;
  endproperty
  a_pulse_ends: assert property (p_pulse_ends) else $error("clock stuck high");
endmodule : sync_tx_props
bind sync_serial_master_transmit sync_tx_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .shift_clock_o(shift_clock_o), .shift_clock_oe(shift_clock_oe),
  .serial_data_o(serial_data_o), .serial_data_oe(serial_data_oe));
`default_nettype wire

// ### verification/sync_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module sync_slave_model (
  input  wire logic   sck,     // master clock line
  input  wire logic   sdata,   // resolved data line
  input  wire logic   clr,     // empty capture
  output logic [15:0] rx_bits, // newest bit at top
  output int          rx_count // bits taken
);
  // receive only: never drives the shared data line
  // samples on trailing edge, data bits only, no framing
  always @(posedge sck or posedge clr)
  begin
    if (clr)
    begin
      rx_bits  <= 16'h0000;
      rx_count <= 0;
    end
    else
    begin
      rx_bits  <= {sdata, rx_bits[15:1]};
      rx_count <= rx_count + 1;
    end
  end
endmodule : sync_slave_model
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0, dlast = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, ck_o, ck_oe, d_o, d_oe, irq;
  logic [15:0] rx_bits;
  int rx_count, errors = 0, checks_done = 0;
  int hi_run = 0, hi_len = 0;
  wire ck_line = ck_oe ? ck_o : 1'b0;
  wire d_line = d_oe ? d_o : ~dlast; // released line shows no stale bit
  sync_serial_master_transmit DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .shift_clock_o(ck_o), .shift_clock_oe(ck_oe),
    .shift_clock_i(ck_line), .serial_data_o(d_o), .serial_data_oe(d_oe),
    .serial_data_i(d_line), .irq(irq));
  sync_slave_model u_slave (.sck(ck_line), .sdata(d_line), .clr(clr), .rx_bits(rx_bits),
    .rx_count(rx_count));
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) if (d_oe) dlast <= d_o;
  // length in pclk cycles of the last finished high clock phase
  always @(posedge pclk)
  begin
    hi_run <= ck_o ? hi_run + 1 : 0;
    if (!ck_o && hi_run != 0)
      hi_len <= hi_run;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    chk("slverr", {31'h0, a > 8'h18}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task send(input logic [7:0] c, input int n, input logic [15:0] e, input int h);
    clr <= 1'b1;
    apb(1, sync_tx_pkg::OFS_TX_HOLDING, {24'h0, c});
    clr <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(0, sync_tx_pkg::OFS_TX_STATUS_CONTROL, 0);
    chk("busy", 32'h0, {31'h0, rd[1]});
    repeat (n * 20) @(posedge pclk);
    apb(0, sync_tx_pkg::OFS_TX_STATUS_CONTROL, 0);
    chk("empty", 32'h1, {31'h0, rd[1]});
    chk("clocks", n, rx_count);
    chk("bits", e, rx_bits);
    chk("half bit", h, hi_len);
  endtask : send
  task t_reset;
    chk("oe", 32'h0, {30'h0, ck_oe, d_oe});
    apb(0, sync_tx_pkg::OFS_TX_STATUS_CONTROL, 0);
    chk("txsc", 32'h0000_0002, rd);
    apb(0, sync_tx_pkg::OFS_TX_HOLDING, 0);
    chk("holding", 32'h0, rd);
    apb(0, 8'h1C, 0);
  endtask : t_reset
  task t_modes;
    apb(1, sync_tx_pkg::OFS_RX_STATUS_CONTROL, 32'h0000_00A0);
    apb(1, sync_tx_pkg::OFS_TX_STATUS_CONTROL, 32'h0000_00B0);
    repeat (2) @(posedge pclk);
    chk("rx oe", 32'h2, {30'h0, ck_oe, d_oe});
    apb(1, sync_tx_pkg::OFS_RX_STATUS_CONTROL, 32'h0000_0090);
    repeat (2) @(posedge pclk);
    chk("crx oe", 32'h2, {30'h0, ck_oe, d_oe});
    apb(1, sync_tx_pkg::OFS_RX_STATUS_CONTROL, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("off oe", 32'h0, {30'h0, ck_oe, d_oe});
    apb(1, sync_tx_pkg::OFS_RX_STATUS_CONTROL, 32'h0000_0080);
    apb(1, sync_tx_pkg::OFS_TX_STATUS_CONTROL, 32'h0000_0030);
    repeat (2) @(posedge pclk);
    chk("slave oe", 32'h0, {30'h0, ck_oe, d_oe});
    apb(1, sync_tx_pkg::OFS_TX_STATUS_CONTROL, 32'h0000_00B0);
    repeat (2) @(posedge pclk);
    chk("tx oe", 32'h3, {30'h0, ck_oe, d_oe});
  endtask : t_modes
  task t_irq;
    apb(1, sync_tx_pkg::OFS_PERIPH_IRQ_EN_1, 32'h0000_0010);
    chk("irq off", 32'h0, {31'h0, irq});
    apb(1, sync_tx_pkg::OFS_CORE_IRQ_CONTROL, 32'h0000_00C0);
    repeat (2) @(posedge pclk);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1, sync_tx_pkg::OFS_CORE_IRQ_CONTROL, 32'h0000_0080);
    repeat (2) @(posedge pclk);
    chk("irq gated", 32'h0, {31'h0, irq});
  endtask : t_irq
  task t_burst;
    clr <= 1'b1;
    apb(1, sync_tx_pkg::OFS_TX_HOLDING, 32'h0000_003C);
    clr <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1, sync_tx_pkg::OFS_TX_HOLDING, 32'h0000_00C3);
    apb(0, sync_tx_pkg::OFS_PERIPH_IRQ_FLAG_1, 0);
    chk("flag full", 32'h0, {31'h0, rd[4]});
    repeat (400) @(posedge pclk);
    chk("two chars", 32'h0000_C33C, {16'h0, rx_bits});
    chk("count", 16, rx_count);
  endtask : t_burst
  task print_verdict;
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    #50us;
    errors++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_irq();
    send(8'hA5, 8, 16'hA500, 4);
    t_burst();
    apb(1, sync_tx_pkg::OFS_BAUD_DIVIDER, 32'h0000_0002);
    apb(0, sync_tx_pkg::OFS_BAUD_DIVIDER, 0);
    chk("baud", 32'h0000_0002, rd);
    apb(1, sync_tx_pkg::OFS_TX_STATUS_CONTROL, 32'h0000_00B4);
    send(8'h96, 8, 16'h9600, 3);
    apb(1, sync_tx_pkg::OFS_TX_STATUS_CONTROL, 32'h0000_00F5);
    send(8'h5A, 9, 16'hAD00, 3);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
